// ### verilog/gwae_engine.v
// Added by the designer: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "gwae_map.vh"

module gwae_engine #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW = 4
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [5:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   // Graphics RAM port
   output wire [10:0] ram_addr_o,
   output wire ram_re_o,
   input wire [15:0] ram_rdata_i,
   output wire ram_we_o,
   output wire [15:0] ram_wdata_o,
   output wire [15:0] ram_bwe_o
);

   localparam S_IDLE = 2'h0;
   localparam S_RWAIT = 2'h1;
   localparam S_LATCH = 2'h2;
   localparam S_WRITE = 2'h3;

   // Configuration
   reg dir_q;
   reg [1:0] address_move_dir_q;
   reg [1:0] logic_op_select_q;
   reg [2:0] bit_rotate_amount_q;
   reg [15:0] write_bit_mask_q;
   // Address counter and two-word parity
   reg [10:0] ram_addr_counter_q;
   reg even_q;
   // Engine
   reg [1:0] state_q;
   reg [15:0] word_q;
   reg [15:0] latch_q;
   reg [10:0] ram_addr_q;
   reg ram_re_q;
   reg ram_we_q;
   reg [15:0] ram_wdata_q;
   reg [15:0] ram_bwe_q;
   // Bus
   reg ack_q;
   reg [31:0] dat_q;

   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_out_ready;
   wire [15:0] fifo_out_data;
   wire fifo_empty;
   wire fifo_full;
   wire drained;
   wire wb_hit;
   wire wb_ok;
   wire wb_take;
   wire wb_write;
   wire cfg_reg;
   wire fifo_push;
   wire [15:0] rotated;
   wire [15:0] protect;
   wire [15:0] combined;
   wire [31:0] entry_rd;
   wire [31:0] status_rd;

   // Rotate right by n bits
   function [15:0] rot16;
      input [15:0] d;
      input [2:0] n;
      reg [31:0] dd;
      begin
         dd = {d, d} >> n;
         rot16 = dd[15:0];
      end
   endfunction

   // Byte-lane merge of a Wishbone write into a 32-bit image
   function [31:0] wb_merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] sel;
      integer i;
      begin
         wb_merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               wb_merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // Combine stored and host data
   function [15:0] logic_op;
      input [1:0] op;
      input [15:0] stored;
      input [15:0] host;
      begin
         case (op)
            `GWAE_LG_OR: logic_op = stored | host;
            `GWAE_LG_AND: logic_op = stored & host;
            `GWAE_LG_XOR: logic_op = stored ^ host;
            default: logic_op = host;
         endcase
      end
   endfunction

   // Address counter step after a write
   function [10:0] next_addr;
      input [10:0] ac;
      input [1:0] am;
      input dir;
      input even;
      reg [3:0] col;
      begin
         col = ac[3:0];
         case (am)
            `GWAE_AM_VERT: begin
               if (ac[10:4] == 7'h7f) begin
                  if (dir) begin
                     next_addr = {7'h00, col + 4'h1};
                  end else begin
                     next_addr = {7'h00, col - 4'h1};
                  end
               end else begin
                  next_addr = ac + `GWAE_ROW_WORDS;
               end
            end
            `GWAE_AM_TWO: begin
               if (!even) begin
                  next_addr = dir ? ac + 11'h001 : ac - 11'h001;
               end else if (dir) begin
                  next_addr = ac - 11'h001 + `GWAE_ROW_WORDS;
               end else begin
                  next_addr = ac + 11'h001 + `GWAE_ROW_WORDS;
               end
            end
            default: begin
               // Move mode 11 has no pattern of its own and steps as horizontal
               // Incrementing past column 15 already lands on the next row's left edge
               if (dir) begin
                  next_addr = ac + 11'h001;
               end else if (col == 4'h0) begin
                  next_addr = ac + `GWAE_ROW_WORDS + {7'h00, `GWAE_COL_LAST};
               end else begin
                  next_addr = ac - 11'h001;
               end
            end
         endcase
      end
   endfunction

   gwae_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(wb_dat_i[15:0]),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_out_ready),
      .out_data_o(fifo_out_data),
      .empty_o(fifo_empty),
      .full_o(fifo_full)
   );

   assign fifo_out_ready = (state_q == S_IDLE);
   assign drained = fifo_empty & (state_q == S_IDLE);

   // Bus decode; settings only change once queued words are written, so each word uses its own setup
   // Unmapped offsets are still acknowledged so a stray access cannot hang the bus
   assign wb_hit = wb_cyc_i & wb_stb_i & ~ack_q;
   assign cfg_reg = (wb_adr_i == `GWAE_OFS_ENTRY) | (wb_adr_i == `GWAE_OFS_ROTATE) |
                    (wb_adr_i == `GWAE_OFS_MASK) | (wb_adr_i == `GWAE_OFS_ADDR);
   assign wb_ok = ~wb_we_i | ((wb_adr_i == `GWAE_OFS_WDATA) ? fifo_in_ready : (~cfg_reg | drained));
   assign wb_take = wb_hit & wb_ok;
   assign wb_write = wb_take & wb_we_i;
   assign fifo_push = wb_write & (wb_adr_i == `GWAE_OFS_WDATA);

   assign entry_rd = {27'h0000000, logic_op_select_q, address_move_dir_q, dir_q};
   assign status_rd = {13'h0000, fifo_full, ~drained, even_q, 5'h00, ram_addr_counter_q};

   // Data path toward the RAM
   assign rotated = rot16(word_q, bit_rotate_amount_q);
   assign protect = (address_move_dir_q == `GWAE_AM_TWO && even_q) ? ~write_bit_mask_q
                                                                   : write_bit_mask_q;
   assign combined = logic_op(logic_op_select_q, latch_q, rotated);

   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
      end else begin
         ack_q <= wb_take;
         if (wb_take && !wb_we_i) begin
            case (wb_adr_i)
               `GWAE_OFS_ENTRY: dat_q <= entry_rd;
               `GWAE_OFS_ROTATE: dat_q <= {29'h00000000, bit_rotate_amount_q};
               `GWAE_OFS_MASK: dat_q <= {16'h0000, write_bit_mask_q};
               `GWAE_OFS_ADDR: dat_q <= {21'h000000, ram_addr_counter_q};
               `GWAE_OFS_STATUS: dat_q <= status_rd;
               default: dat_q <= 32'h00000000;
            endcase
         end else begin
            dat_q <= 32'h00000000;
         end
      end
   end

   // Configuration registers
   always @(posedge clk_i) begin : cfg_proc
      reg [31:0] m;
      m = 32'h00000000;
      if (rst_i) begin
         dir_q <= `GWAE_RST_DIR;
         address_move_dir_q <= `GWAE_RST_AM;
         logic_op_select_q <= `GWAE_RST_LG;
         bit_rotate_amount_q <= `GWAE_RST_ROT;
         write_bit_mask_q <= `GWAE_RST_MASK;
      end else if (wb_write) begin
         case (wb_adr_i)
            `GWAE_OFS_ENTRY: begin
               m = wb_merge(entry_rd, wb_dat_i, wb_sel_i);
               dir_q <= m[`GWAE_ENTRY_DIR_BIT];
               address_move_dir_q <= m[`GWAE_ENTRY_AM_LSB +: 2];
               logic_op_select_q <= m[`GWAE_ENTRY_LG_LSB +: 2];
            end
            `GWAE_OFS_ROTATE: begin
               m = wb_merge({29'h00000000, bit_rotate_amount_q}, wb_dat_i, wb_sel_i);
               bit_rotate_amount_q <= m[2:0];
            end
            `GWAE_OFS_MASK: begin
               m = wb_merge({16'h0000, write_bit_mask_q}, wb_dat_i, wb_sel_i);
               write_bit_mask_q <= m[15:0];
            end
            default: begin
               m = 32'h00000000;
            end
         endcase
      end
   end

   // Address counter, parity and write engine
   always @(posedge clk_i) begin : eng_proc
      reg [31:0] a;
      a = 32'h00000000;
      if (rst_i) begin
         ram_addr_counter_q <= `GWAE_RST_AC;
         even_q <= 1'b0;
         state_q <= S_IDLE;
         word_q <= 16'h0000;
         latch_q <= 16'h0000;
         ram_addr_q <= `GWAE_RST_AC;
         ram_re_q <= 1'b0;
         ram_we_q <= 1'b0;
         ram_wdata_q <= 16'h0000;
         ram_bwe_q <= 16'h0000;
      end else begin
         ram_re_q <= 1'b0;
         ram_we_q <= 1'b0;
         if (wb_write && wb_adr_i == `GWAE_OFS_ADDR) begin
            a = wb_merge({21'h000000, ram_addr_counter_q}, wb_dat_i, wb_sel_i);
            ram_addr_counter_q <= a[10:0];
            even_q <= 1'b0;
         end
         case (state_q)
            S_IDLE: begin
               // Popping only here spaces RAM accesses, so a write never meets the next read
               if (fifo_out_valid) begin
                  word_q <= fifo_out_data;
                  ram_addr_q <= ram_addr_counter_q;
                  if (logic_op_select_q != `GWAE_LG_NONE) begin
                     ram_re_q <= 1'b1;
                     state_q <= S_RWAIT;
                  end else begin
                     state_q <= S_WRITE;
                  end
               end
            end
            S_RWAIT: begin
               state_q <= S_LATCH;
            end
            S_LATCH: begin
               // Original word is held internally and never returned on the bus
               latch_q <= ram_rdata_i;
               state_q <= S_WRITE;
            end
            S_WRITE: begin
               ram_we_q <= 1'b1;
               ram_wdata_q <= (logic_op_select_q != `GWAE_LG_NONE) ? combined : rotated;
               ram_bwe_q <= ~protect;
               ram_addr_counter_q <= next_addr(ram_addr_counter_q, address_move_dir_q, dir_q, even_q);
               if (address_move_dir_q == `GWAE_AM_TWO) begin
                  even_q <= ~even_q;
               end
               state_q <= S_IDLE;
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign ram_addr_o = ram_addr_q;
   assign ram_re_o = ram_re_q;
   assign ram_we_o = ram_we_q;
   assign ram_wdata_o = ram_wdata_q;
   assign ram_bwe_o = ram_bwe_q;

endmodule // gwae_engine

`default_nettype wire

// ### verilog/gwae_map.vh
`ifndef GWAE_MAP_VH
`define GWAE_MAP_VH

// Wishbone register offsets (byte addresses)
`define GWAE_OFS_ENTRY 6'h00
`define GWAE_OFS_ROTATE 6'h04
`define GWAE_OFS_MASK 6'h08
`define GWAE_OFS_ADDR 6'h0c
`define GWAE_OFS_WDATA 6'h10
`define GWAE_OFS_STATUS 6'h14

// Entry register fields
`define GWAE_ENTRY_DIR_BIT 0
`define GWAE_ENTRY_AM_LSB 1
`define GWAE_ENTRY_LG_LSB 3

// Status register fields
`define GWAE_STAT_AC_LSB 0
`define GWAE_STAT_EVEN_BIT 16
`define GWAE_STAT_BUSY_BIT 17
`define GWAE_STAT_FULL_BIT 18

// Reset values
`define GWAE_RST_DIR 1'b1
`define GWAE_RST_AM 2'h0
`define GWAE_RST_LG 2'h0
`define GWAE_RST_ROT 3'h0
`define GWAE_RST_MASK 16'h0000
`define GWAE_RST_AC 11'h000

// Address move modes
`define GWAE_AM_HORIZ 2'h0
`define GWAE_AM_VERT 2'h1
`define GWAE_AM_TWO 2'h2

// Logic operations
`define GWAE_LG_NONE 2'h0
`define GWAE_LG_OR 2'h1
`define GWAE_LG_AND 2'h2
`define GWAE_LG_XOR 2'h3

// Geometry: sixteen words per raster row
`define GWAE_ROW_WORDS 11'h010
`define GWAE_COL_LAST 4'hf

`endif

// ### verilog/gwae_fifo.v
`timescale 1ns/1ps
`default_nettype none

module gwae_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   // Drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   // Status
   output wire empty_o,
   output wire full_o
);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_q;
   reg [AW-1:0] rd_ptr_q;
   reg [AW:0] count_q;
   reg [WIDTH-1:0] out_q;
   reg out_valid_q;
   wire push;
   wire load;

   // Read data always leaves through a register, so the output stage counts as one extra slot
   assign full_o = (count_q == DEPTH[AW:0]);
   assign in_ready_o = ~full_o;
   assign push = in_valid_i & ~full_o;
   assign load = (count_q != {(AW+1){1'b0}}) & (~out_valid_q | out_ready_i);
   assign out_valid_o = out_valid_q;
   assign out_data_o = out_q;
   assign empty_o = ~out_valid_q & (count_q == {(AW+1){1'b0}});

   always @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr_q <= {AW{1'b0}};
         rd_ptr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
         out_q <= {WIDTH{1'b0}};
         out_valid_q <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (load) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
            out_q <= mem_q[rd_ptr_q];
            out_valid_q <= 1'b1;
         end else if (out_ready_i) begin
            out_valid_q <= 1'b0;
         end
         if (push & ~load) begin
            count_q <= count_q + 1'b1;
         end else if (load & ~push) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule // gwae_fifo

`default_nettype wire

// ### verification/gwae_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module gwae_monitor (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [5:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   // Graphics RAM port
   input wire logic [10:0] ram_addr_o,
   input wire logic ram_re_o,
   input wire logic [15:0] ram_rdata_i,
   input wire logic ram_we_o,
   input wire logic [15:0] ram_wdata_o,
   input wire logic [15:0] ram_bwe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held past one cycle");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_RE_TO_WE: assert property (ram_re_o |-> ##3 ram_we_o)
      else $error("no write back after read");
   AST_RE_HOLD: assert property (ram_re_o |=> $stable(ram_addr_o) [*3])
      else $error("address moved during read modify write");
   AST_RE_QUIET: assert property (ram_re_o |=> (!ram_re_o && !ram_we_o) [*2])
      else $error("strobe during read latency");
   AST_WE_ONE: assert property (ram_we_o |=> !ram_we_o)
      else $error("write strobe too long");
   AST_RE_WE_EXCL: assert property (!(ram_re_o && ram_we_o))
      else $error("read and write strobe together");
   AST_WE_HELD: assert property (ram_we_o |-> $stable(ram_addr_o))
      else $error("address changed with write");
endmodule // gwae_monitor

bind gwae_engine gwae_monitor mon_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .ram_addr_o, .ram_re_o, .ram_rdata_i, .ram_we_o, .ram_wdata_o, .ram_bwe_o);

`default_nettype wire

// ### verification/gwae_ram_model.sv
`timescale 1ns/1ps
`default_nettype none

module gwae_ram_model (
   // Clock
   input wire logic clk_i,
   // Access
   input wire logic [10:0] addr_i,
   input wire logic re_i,
   input wire logic we_i,
   input wire logic [15:0] wdata_i,
   input wire logic [15:0] bwe_i,
   output logic [15:0] rdata_o
);
   logic [15:0] mem_q [0:2047];
   logic [15:0] rd_q = 16'h0000;

   assign rdata_o = rd_q;

   initial begin
      for (int i = 0; i < 2048; i++) begin
         mem_q[i] = 16'(i * 40503);
      end
   end

   always @(posedge clk_i) begin
      // Flipping data when unread, so a late sample cannot pass by luck
      if (re_i) begin
         rd_q <= mem_q[addr_i];
      end else begin
         rd_q <= ~rd_q;
      end
      if (we_i) begin
         mem_q[addr_i] <= (mem_q[addr_i] & ~bwe_i) | (wdata_i & bwe_i);
      end
   end
endmodule // gwae_ram_model

`default_nettype wire

// ### verification/tb_gram_write_address_engine.sv
`timescale 1ns/1ps
`default_nettype none
`include "gwae_map.vh"

module tb_gram_write_address_engine;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [5:0] adr = 6'h00;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   wire [31:0] dat_o;
   wire ack, re, wen;
   wire [10:0] ra;
   wire [15:0] rd, wd, bwe;
   int err_total = 0;
   int checked = 0;
   int wait_max = 0;
   logic [31:0] seed = 32'h3c3b;
   logic [15:0] mem [0:2047];
   logic [42:0] exp_q [$];
   logic [42:0] e_w;
   logic [10:0] ac = 11'h000;
   logic dir = 1'b1;
   logic par = 1'b0;
   logic [1:0] am = 2'h0;
   logic [1:0] lg = 2'h0;
   logic [2:0] rot = 3'h0;
   logic [15:0] mask = 16'h0000;

   gwae_engine dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .ram_addr_o(ra),
      .ram_re_o(re), .ram_rdata_i(rd), .ram_we_o(wen), .ram_wdata_o(wd), .ram_bwe_o(bwe));
   gwae_ram_model ram_u (.clk_i(clk_i), .addr_i(ra), .re_i(re), .we_i(wen), .wdata_i(wd), .bwe_i(bwe),
      .rdata_o(rd));

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic report_and_stop();
      $display("mismatches %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // No fixed latency assumed: the watchdog ends a wait that never sees ack
   task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= (a == `GWAE_OFS_WDATA) ? 4'(rnd()) : 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1);
      if (n > wait_max) begin
         wait_max = n;
      end
      r = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic push(input logic [15:0] d);
      logic [31:0] t;
      logic [15:0] b, s, v;
      logic [3:0] c;
      t = {d, d} >> rot;
      b = (am == `GWAE_AM_TWO && par) ? mask : ~mask;
      s = mem[ac];
      v = lg == 2'h1 ? (s | t[15:0]) : lg == 2'h2 ? (s & t[15:0]) : lg == 2'h3 ? (s ^ t[15:0]) : t[15:0];
      exp_q.push_back({ac, b, v & b});
      mem[ac] = (s & ~b) | (v & b);
      c = dir ? ac[3:0] + 4'h1 : ac[3:0] - 4'h1;
      if (am == `GWAE_AM_VERT) begin
         ac = (ac >= 11'h7f0) ? {7'h00, c} : ac + 11'h010;
      end else if (am == `GWAE_AM_TWO) begin
         ac = par ? (dir ? ac + 11'h00f : ac + 11'h011) : (dir ? ac + 11'h001 : ac - 11'h001);
         par = ~par;
      end else begin
         ac = (!dir && ac[3:0] == 4'h0) ? ac + 11'h01f : (dir ? ac + 11'h001 : ac - 11'h001);
      end
      wb(1'b1, `GWAE_OFS_WDATA, {16'(rnd()), d}, t);
   endtask

   always @(posedge clk_i) begin
      if (wen === 1'b1) begin
         e_w = exp_q.pop_front();
         chk("ram address", 32'(e_w[42:32]), 32'(ra));
         chk("bit enables", 32'(e_w[31:16]), 32'(bwe));
         chk("write data", 32'(e_w[15:0]), 32'(wd & bwe));
      end
   end

   initial begin
      logic [31:0] r, x;
      for (int i = 0; i < 2048; i++) begin
         mem[i] = 16'(i * 40503);
      end
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wb(1'b1, 6'h1c, 32'hffffffff, r);
      for (int k = 0; k < 7; k++) begin
         wb(1'b0, 6'(k * 4), 32'h0, r);
         chk("reset read", k == 0 ? 32'h1 : 32'h0, r);
      end
      for (int m = 0; m < 16; m++) begin
         x = rnd();
         am = 2'(m % 4);
         lg = 2'(m / 4);
         dir = x[0];
         rot = x[3:1];
         mask = x[31:16];
         wb(1'b1, `GWAE_OFS_ENTRY, {27'h0, lg, am, dir}, r);
         wb(1'b1, `GWAE_OFS_ROTATE, 32'(rot), r);
         wb(1'b1, `GWAE_OFS_MASK, 32'(mask), r);
         // Vertical runs start high in the RAM, from 11'h700 up, so the bottom wrap is reached
         ac = 11'(rnd()) | (am == `GWAE_AM_VERT ? 11'h700 : 11'h000);
         par = 1'b0;
         wb(1'b1, `GWAE_OFS_ADDR, 32'(ac), r);
         // The last run pushes faster than the logic engine drains, so the queue fills and stalls
         repeat (m == 15 ? 80 : 20) push(16'(rnd()));
         do wb(1'b0, `GWAE_OFS_STATUS, 32'h0, r); while (r[17] !== 1'b0);
         chk("status", {15'h0, par, 5'h0, ac}, r);
         wb(1'b0, `GWAE_OFS_ADDR, 32'h0, r);
         chk("counter", 32'(ac), r);
         chk("queue left", 32'h0, 32'(exp_q.size()));
      end
      chk("fifo stall seen", 32'h1, 32'(wait_max > 2));
      report_and_stop();
   end

   // About 2000 cycles expected; five times that is a hang
   initial begin
      #200000;
      err_total++;
      report_and_stop();
   end
endmodule // tb_gram_write_address_engine

`default_nettype wire
